// [pkg/accum_defs.vh]
/*
  constants of the accumulator datapath: apb offsets, instruction codes,
  arithmetic type codes, ctrl fields, io banks and ports, reply status.
  assumes inclusion by bare name from rtl files.
*/
`ifndef ACCUM_DEFS_VH
`define ACCUM_DEFS_VH

// ---------------------------------------------------------------
// apb register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFS_CMD_OPCODE   12'h000
`define OFS_CMD_TYPE     12'h004
`define OFS_CMD_BANK     12'h008
`define OFS_CMD_VALUE    12'h00c
`define OFS_CMD_GO       12'h010
`define OFS_CTRL         12'h014
`define OFS_ACCUM        12'h018
`define OFS_REPLY_STATUS 12'h01c
`define OFS_REPLY_VALUE  12'h020
`define OFS_PC           12'h024
`define OFS_FLAGS        12'h028
`define OFS_IRQ_STATUS   12'h02c
`define OFS_IRQ_MASK     12'h030

// ---------------------------------------------------------------
// ctrl register fields
// ---------------------------------------------------------------
`define CTRL_STANDALONE_BIT 0
`define CTRL_OUT_LSB        4

// ---------------------------------------------------------------
// instruction codes
// ---------------------------------------------------------------
`define OP_SET_OUTPUT  8'h0e
`define OP_READ_IO     8'h0f
`define OP_ARITH       8'h13
`define OP_COMPARE     8'h14
`define OP_BRANCH      8'h15

// ---------------------------------------------------------------
// arithmetic type codes
// ---------------------------------------------------------------
`define AR_ADD  8'h00
`define AR_SUB  8'h01
`define AR_MUL  8'h02
`define AR_DIV  8'h03
`define AR_MOD  8'h04
`define AR_AND  8'h05
`define AR_OR   8'h06
`define AR_XOR  8'h07
`define AR_NOT  8'h08
`define AR_LOAD 8'h09

// ---------------------------------------------------------------
// io banks and ports
// ---------------------------------------------------------------
`define BANK_INPUT     8'h00
`define BANK_OUTPUT    8'h02
`define PORT_ENABLE    8'h0a
`define PORT_ALL       8'hff

// ---------------------------------------------------------------
// reply status
// ---------------------------------------------------------------
`define ST_OK          8'h64
`define ST_BAD_CMD     8'h02

`endif

// [rtl/branch_cond.v]
/*
  condition evaluator for the conditional branch.
  assumes flags come from registers of the caller on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module branch_cond (
  input  wire [7:0] cond,
  input  wire       zero_flag,
  input  wire       neg_flag,
  input  wire       timeout_flag,
  input  wire       external_alarm_flag,
  input  wire       deviation_error_flag,
  input  wire       position_error_flag,
  output reg        taken
);

  // ---------------------------------------------------------------
  // condition select
  // ---------------------------------------------------------------
  always @* begin
    case (cond)
      8'h00: taken = zero_flag;
      8'h01: taken = ~zero_flag;
      8'h02: taken = zero_flag;
      8'h03: taken = ~zero_flag;
      8'h04: taken = ~zero_flag & ~neg_flag;
      8'h05: taken = ~neg_flag;
      8'h06: taken = neg_flag;
      8'h07: taken = neg_flag | zero_flag;
      8'h08: taken = timeout_flag;
      8'h09: taken = external_alarm_flag;
      8'h0a: taken = deviation_error_flag;
      8'h0b: taken = position_error_flag;
      default: taken = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// [rtl/accumulator_alu_branch.v]
/*
  accumulator datapath of a command interpreter: arithmetic, compare,
  conditional branch of the program counter, output read-back and enable
  read-back, with an apb register front end and one interrupt line.
  assumes one clock pclk, async active-low reset, pins are asynchronous.
  limitation: divide or remainder by zero leaves the accumulator as it was.
*/
`timescale 1ns/1ps
`default_nettype none
`include "accum_defs.vh"

module accumulator_alu_branch #(
  parameter PC_W = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        enable_n_pin,
  input  wire        timeout_flag,
  input  wire        external_alarm_flag,
  input  wire        deviation_error_flag,
  input  wire        position_error_flag,
  output wire [3:0]  digital_outputs,
  output wire        irq
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0]      opcode_r;
  reg  [7:0]      type_r;
  reg  [7:0]      bank_r;
  reg  [31:0]     value_r;
  reg             standalone_r;
  reg  [3:0]      out_r;
  reg  [31:0]     accum_r;
  reg  [7:0]      reply_status_r;
  reg  [31:0]     reply_value_r;
  reg  [PC_W-1:0] pc_r;
  reg             zero_r;
  reg             neg_r;
  reg  [1:0]      irq_status_r;
  reg  [1:0]      irq_mask_r;
  reg  [1:0]      en_sync_r;
  reg  [3:0]      err_s1_r;
  reg  [3:0]      err_s2_r;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // one line of the output bank, shared by set and read so both agree
  function out_line_sel(input [7:0] bank, input [7:0] port);
    out_line_sel = (bank == `BANK_OUTPUT) && (port < 8'h04);
  endfunction

  // whole output vector at once
  function out_vec_sel(input [7:0] bank, input [7:0] port);
    out_vec_sel = (bank == `BANK_OUTPUT) && (port == `PORT_ALL);
  endfunction

  // write access phase aimed at one register offset
  function wr_hit(input wr, input [11:0] addr, input [11:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc_w   = psel & penable & pwrite;
  wire acc_r   = psel & penable & ~pwrite;
  wire known   = (paddr[1:0] == 2'b00) && (paddr <= `OFS_IRQ_MASK);
  wire go      = wr_hit(acc_w, paddr, `OFS_CMD_GO) && pwdata[0];

  // reads have no side effect and the mux is shallow, so no wait state
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_sync_r <= 2'b11;
      err_s1_r  <= 4'h0;
      err_s2_r  <= 4'h0;
    end else begin
      en_sync_r <= {en_sync_r[0], enable_n_pin};
      err_s1_r  <= {position_error_flag, deviation_error_flag,
                    external_alarm_flag, timeout_flag};
      err_s2_r  <= err_s1_r;
    end
  end

  wire enable_n = en_sync_r[1];

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  wire signed [31:0] acc_s = accum_r;
  wire signed [31:0] opd_s = value_r;
  wire signed [63:0] prod  = acc_s * opd_s;
  wire        div_zero = (value_r == 32'h0000_0000);
  // divide by zero keeps the accumulator; software must avoid it
  wire signed [31:0] quot  = div_zero ? acc_s : acc_s / opd_s;
  wire signed [31:0] remd  = div_zero ? acc_s : acc_s % opd_s;
  wire [31:0] diff = accum_r - value_r;
  wire        lt   = acc_s < opd_s;

  reg  [31:0] arith_res;
  reg         arith_ok;
  always @* begin
    arith_ok = 1'b1;
    case (type_r)
      `AR_ADD:  arith_res = accum_r + value_r;
      `AR_SUB:  arith_res = diff;
      `AR_MUL:  arith_res = prod[31:0];
      `AR_DIV:  arith_res = quot;
      `AR_MOD:  arith_res = remd;
      `AR_AND:  arith_res = accum_r & value_r;
      `AR_OR:   arith_res = accum_r | value_r;
      `AR_XOR:  arith_res = accum_r ^ value_r;
      `AR_NOT:  arith_res = ~accum_r;
      `AR_LOAD: arith_res = value_r;
      default: begin
        arith_res = accum_r;
        arith_ok  = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // port read
  // ---------------------------------------------------------------
  reg [31:0] port_val;
  reg        port_ok;
  always @* begin
    port_ok  = 1'b1;
    port_val = 32'h0000_0000;
    if (out_line_sel(bank_r, type_r))
      port_val = {31'h0, out_r[type_r[1:0]]};
    else if (out_vec_sel(bank_r, type_r))
      port_val = {28'h0, out_r};
    else if (bank_r == `BANK_INPUT && type_r == `PORT_ENABLE)
      port_val = {31'h0, enable_n};
    else
      port_ok = 1'b0;
  end

  // ---------------------------------------------------------------
  // branch condition
  // ---------------------------------------------------------------
  wire taken;
  branch_cond u_cond (
    .cond                 (type_r),
    .zero_flag            (zero_r),
    .neg_flag             (neg_r),
    .timeout_flag         (err_s2_r[0]),
    .external_alarm_flag  (err_s2_r[1]),
    .deviation_error_flag (err_s2_r[2]),
    .position_error_flag  (err_s2_r[3]),
    .taken                (taken)
  );

  // ---------------------------------------------------------------
  // command execution
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_r        <= 32'h0000_0000;
      reply_status_r <= 8'h00;
      reply_value_r  <= 32'h0000_0000;
      pc_r           <= {PC_W{1'b0}};
      zero_r         <= 1'b0;
      neg_r          <= 1'b0;
      out_r          <= 4'h0;
    end else if (go) begin
      reply_status_r <= `ST_OK;
      reply_value_r  <= 32'h0000_0000;
      pc_r           <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
      case (opcode_r)
        `OP_ARITH: begin
          if (arith_ok) begin
            accum_r       <= arith_res;
            reply_value_r <= value_r;
          end else
            reply_status_r <= `ST_BAD_CMD;
        end
        `OP_COMPARE: begin
          zero_r <= (diff == 32'h0000_0000);
          neg_r  <= lt;
        end
        `OP_BRANCH: begin
          if (taken)
            pc_r <= value_r[PC_W-1:0];
        end
        `OP_READ_IO: begin
          if (port_ok) begin
            reply_value_r <= port_val;
            if (standalone_r)
              accum_r <= port_val;
          end else
            reply_status_r <= `ST_BAD_CMD;
        end
        `OP_SET_OUTPUT: begin
          if (out_line_sel(bank_r, type_r))
            out_r[type_r[1:0]] <= value_r[0];
          else if (out_vec_sel(bank_r, type_r))
            out_r <= (value_r == 32'hffff_ffff) ? accum_r[3:0] : value_r[3:0];
          else
            reply_status_r <= `ST_BAD_CMD;
        end
        default: reply_status_r <= `ST_BAD_CMD;
      endcase
    end
  end

  assign digital_outputs = out_r;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // read-only and unmapped offsets fall to the default and are ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_r     <= 8'h00;
      type_r       <= 8'h00;
      bank_r       <= 8'h00;
      value_r      <= 32'h0000_0000;
      standalone_r <= 1'b0;
      irq_mask_r   <= 2'b00;
    end else if (acc_w) begin
      case (paddr)
        `OFS_CMD_OPCODE: opcode_r     <= pwdata[7:0];
        `OFS_CMD_TYPE:   type_r       <= pwdata[7:0];
        `OFS_CMD_BANK:   bank_r       <= pwdata[7:0];
        `OFS_CMD_VALUE:  value_r      <= pwdata;
        `OFS_CTRL:       standalone_r <= pwdata[`CTRL_STANDALONE_BIT];
        `OFS_IRQ_MASK:   irq_mask_r   <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  wire       cmd_done = go;
  wire       br_taken = go && taken && (opcode_r == `OP_BRANCH);
  wire [1:0] irq_set  = {br_taken, cmd_done};
  wire [1:0] irq_clr  = wr_hit(acc_w, paddr, `OFS_IRQ_STATUS) ? pwdata[1:0] : 2'b00;

  // a set in the same cycle as a write-one clear wins, so no event is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_status_r <= 2'b00;
    else
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always @* begin
    case (paddr)
      `OFS_CMD_OPCODE:   prdata = {24'h0, opcode_r};
      `OFS_CMD_TYPE:     prdata = {24'h0, type_r};
      `OFS_CMD_BANK:     prdata = {24'h0, bank_r};
      `OFS_CMD_VALUE:    prdata = value_r;
      `OFS_CTRL:         prdata = {24'h0, out_r, 3'h0, standalone_r};
      `OFS_ACCUM:        prdata = accum_r;
      `OFS_REPLY_STATUS: prdata = {24'h0, reply_status_r};
      `OFS_REPLY_VALUE:  prdata = reply_value_r;
      `OFS_PC:           prdata = {{(32-PC_W){1'b0}}, pc_r};
      `OFS_FLAGS:        prdata = {26'h0, err_s2_r, neg_r, zero_r};
      `OFS_IRQ_STATUS:   prdata = {30'h0, irq_status_r};
      `OFS_IRQ_MASK:     prdata = {30'h0, irq_mask_r};
      default:           prdata = 32'h0000_0000;
    endcase
  end

endmodule

`default_nettype wire

// [verif/accum_checker_properties.sv]
/* checker: port relations of the accumulator block.
   assumes it is bound to accumulator_alu_branch, one clock pclk. */
`timescale 1ns/1ps
`default_nettype none
`include "accum_defs.vh"
module accum_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [3:0]  digital_outputs,
  input wire        irq
);
  wire       acc_ph = psel & penable;
  wire       wr     = acc_ph & pwrite;
  wire       rd     = acc_ph & ~pwrite;
  wire       go     = wr & (paddr == `OFS_CMD_GO) & pwdata[0];
  reg  [7:0] op_r, ty_r, lop_r, lty_r;
  reg [31:0] val_r, lval_r, acc_r;
  reg        sa_r, lsa_r, keep_r;
  // shadow of the command fields as they stood at the last start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {op_r, ty_r, lop_r, lty_r, val_r, lval_r, acc_r, sa_r, lsa_r, keep_r} <= '0;
    end else if (rd && paddr == `OFS_ACCUM) begin
      keep_r <= 1'b1;
      acc_r <= prdata;
    end else if (wr) begin
      if (go) keep_r <= keep_r && op_r == `OP_COMPARE;
      case (paddr)
        `OFS_CMD_OPCODE: op_r <= pwdata[7:0];
        `OFS_CMD_TYPE: ty_r <= pwdata[7:0];
        `OFS_CMD_VALUE: val_r <= pwdata;
        `OFS_CTRL: sa_r <= pwdata[0];
        `OFS_CMD_GO: {lop_r, lty_r, lval_r, lsa_r} <= {op_r, ty_r, val_r, sa_r};
        default: ;
      endcase
    end
  end
  wire arith_ok = lop_r == `OP_ARITH && lty_r <= 8'h09 && !lsa_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (acc_ph |-> pready) else $error("pready low");
  a_slverr_map: assert property (acc_ph |-> pslverr == (paddr > `OFS_IRQ_MASK || paddr[1:0] != 2'b00))
    else $error("pslverr wrong");
  a_out_readback: assert property (rd && paddr == `OFS_CTRL |-> prdata[7:4] == digital_outputs)
    else $error("output readback wrong");
  a_out_cause: assert property ($changed(digital_outputs) |-> $past(go) && lop_r == `OP_SET_OUTPUT)
    else $error("outputs moved without command");
  a_reply_stat: assert property (rd && paddr == `OFS_REPLY_STATUS && arith_ok |-> prdata[7:0] == `ST_OK)
    else $error("arith status wrong");
  a_reply_echo: assert property (rd && paddr == `OFS_REPLY_VALUE && arith_ok |-> prdata == lval_r)
    else $error("arith reply value wrong");
  a_cmp_keeps: assert property (rd && paddr == `OFS_ACCUM && keep_r |-> prdata == acc_r)
    else $error("accumulator moved");
  a_irq_rise: assert property ($rose(irq) |-> $past(go || (wr && paddr == `OFS_IRQ_MASK)))
    else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr && (paddr == `OFS_IRQ_MASK || paddr == `OFS_IRQ_STATUS)))
    else $error("irq fell without cause");
  c_irq: cover property ($rose(irq));
  c_out: cover property ($changed(digital_outputs));
  c_keep: cover property (rd && paddr == `OFS_ACCUM && keep_r);
endmodule
bind accumulator_alu_branch accum_checker accum_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .digital_outputs, .irq);
`default_nettype wire

// [verif/apb_host.sv]
/* apb host model: single transfers on behalf of the bench.
   assumes pclk from the bench and a slave answering with pready. */
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // ------------------------------------------------------------
  // one transfer; idle edge first so calls never collide in a step
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      testbench.n_fail++;
      testbench.tally_and_finish();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
/* bench for the accumulator block: commands go through the apb host model.
   assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
`include "accum_defs.vh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, enable_n_pin, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  err, digital_outputs;
  int          n_fail = 0;
  int          tests_run = 0;
  accumulator_alu_branch #(.PC_W(16)) accumulator_alu_branch_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_n_pin, .timeout_flag(err[0]),
    .external_alarm_flag(err[1]), .deviation_error_flag(err[2]), .position_error_flag(err[3]),
    .digital_outputs, .irq);
  apb_host apb_host_inst (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input string s, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb_host_inst.xfer(1'b0, a, 32'h0, q);
    check(s, e, q);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bk, input logic [31:0] v);
    wr(`OFS_CMD_OPCODE, {24'h0, op});
    wr(`OFS_CMD_TYPE, {24'h0, ty});
    wr(`OFS_CMD_BANK, {24'h0, bk});
    wr(`OFS_CMD_VALUE, v);
    wr(`OFS_CMD_GO, 32'h1);
  endtask
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask
  function automatic logic [31:0] alu(input logic [7:0] t, input logic signed [31:0] a, input logic signed [31:0] b);
    case (t)
      `AR_ADD: return a + b;
      `AR_SUB: return a - b;
      `AR_MUL: return a * b;
      `AR_DIV: return a / b;
      `AR_MOD: return a % b;
      `AR_AND: return a & b;
      `AR_OR: return a | b;
      `AR_XOR: return a ^ b;
      `AR_NOT: return ~a;
      default: return b;
    endcase
  endfunction
  function automatic logic cond(input int t, input logic signed [31:0] a, input logic signed [31:0] b);
    logic [7:0] v;
    v = {a <= b, a < b, a >= b, a > b, a != b, a == b, a != b, a == b};
    return v[t];
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rc("accum", `OFS_ACCUM, 32'h0);
    rc("pc", `OFS_PC, 32'h0);
    rc("unmapped", 12'h040, 32'h0);
  endtask
  task automatic t_arith;
    for (int t = 0; t < 10; t++) begin
      cmd(`OP_ARITH, `AR_LOAD, 8'h00, 32'hffffe4a8);
      cmd(`OP_ARITH, t[7:0], 8'h00, 32'hffffec78);
      rc("accum", `OFS_ACCUM, alu(t[7:0], 32'hffffe4a8, 32'hffffec78));
      rc("status", `OFS_REPLY_STATUS, {24'h0, `ST_OK});
      rc("reply", `OFS_REPLY_VALUE, 32'hffffec78);
    end
    cmd(`OP_ARITH, 8'h0a, 8'h00, 32'h1);
    rc("bad type", `OFS_REPLY_STATUS, {24'h0, `ST_BAD_CMD});
  endtask
  task automatic t_branch;
    logic [31:0] b, p;
    for (int k = 0; k < 3; k++) begin
      b = k == 0 ? 32'hfffffffd : (k == 1 ? 32'h00000002 : 32'hffffff00);
      cmd(`OP_ARITH, `AR_LOAD, 8'h00, 32'hfffffffd);
      rc("load", `OFS_ACCUM, 32'hfffffffd);
      cmd(`OP_COMPARE, 8'h07, 8'h03, b);
      rc("accum kept", `OFS_ACCUM, 32'hfffffffd);
      for (int t = 0; t < 8; t++) begin
        apb_host_inst.xfer(1'b0, `OFS_PC, 32'h0, p);
        cmd(`OP_BRANCH, t[7:0], 8'h00, 32'h00001230 + t);
        rc("pc", `OFS_PC, cond(t, 32'hfffffffd, b) ? 32'h00001230 + t : p + 1);
      end
    end
    for (int i = 0; i < 4; i++) begin
      err <= 4'h1 << i;
      settle();
      rc("flags", `OFS_FLAGS, {26'h0, 4'h1 << i, 2'b00});
      for (int t = 8; t < 12; t++) begin
        apb_host_inst.xfer(1'b0, `OFS_PC, 32'h0, p);
        cmd(`OP_BRANCH, t[7:0], 8'h00, 32'h00000040);
        rc("pc err", `OFS_PC, (t - 8 == i) ? 32'h00000040 : p + 1);
      end
    end
    err <= 4'h0;
  endtask
  task automatic t_io;
    for (int p = 0; p < 4; p++) begin
      cmd(`OP_SET_OUTPUT, p[7:0], `BANK_OUTPUT, 32'h1);
      settle();
      check("outputs", 32'h1 << p, {28'h0, digital_outputs});
      cmd(`OP_READ_IO, p[7:0], `BANK_OUTPUT, 32'h0);
      rc("out read", `OFS_REPLY_VALUE, 32'h1);
      cmd(`OP_SET_OUTPUT, p[7:0], `BANK_OUTPUT, 32'h0);
    end
    cmd(`OP_ARITH, `AR_LOAD, 8'h00, 32'h5);
    cmd(`OP_SET_OUTPUT, `PORT_ALL, `BANK_OUTPUT, 32'hffffffff);
    settle();
    check("out vector pins", 32'h5, {28'h0, digital_outputs});
    cmd(`OP_READ_IO, `PORT_ALL, `BANK_OUTPUT, 32'h0);
    rc("out vector read", `OFS_REPLY_VALUE, 32'h5);
    cmd(`OP_SET_OUTPUT, `PORT_ALL, `BANK_OUTPUT, 32'h0);
    for (int e = 0; e < 2; e++) begin
      enable_n_pin <= e[0];
      settle();
      cmd(`OP_READ_IO, `PORT_ENABLE, `BANK_INPUT, 32'h0);
      rc("enable", `OFS_REPLY_VALUE, e);
    end
    cmd(`OP_ARITH, `AR_LOAD, 8'h00, 32'h55);
    cmd(`OP_READ_IO, `PORT_ENABLE, `BANK_INPUT, 32'h0);
    rc("acc direct", `OFS_ACCUM, 32'h55);
    wr(`OFS_CTRL, 32'h1);
    cmd(`OP_READ_IO, `PORT_ENABLE, `BANK_INPUT, 32'h0);
    rc("acc standalone", `OFS_ACCUM, 32'h1);
    wr(`OFS_CTRL, 32'h0);
  endtask
  task automatic t_irq;
    rc("irq status", `OFS_IRQ_STATUS, 32'h3);
    wr(`OFS_IRQ_STATUS, 32'h3);
    cmd(`OP_COMPARE, 8'h00, 8'h00, 32'h0);
    rc("irq done", `OFS_IRQ_STATUS, 32'h1);
    settle();
    check("irq masked", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_MASK, 32'h1);
    settle();
    check("irq raised", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_STATUS, 32'h1);
    settle();
    check("irq cleared", 32'h0, {31'h0, irq});
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    enable_n_pin = 1'b0;
    err = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arith();
    t_branch();
    t_io();
    t_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
